// ==== include/spm_defs.svh ====
`ifndef SPM_DEFS_SVH
`define SPM_DEFS_SVH

// Register indices; byte address is four times the index
`define SPM_IDX_PAGE     6'h02
`define SPM_IDX_CSYNC    6'h05
`define SPM_IDX_PER_LO   6'h06
`define SPM_IDX_PER_HI   6'h07
`define SPM_IDX_GLOB_TOP 6'h07
`define SPM_IDX_PAGED    2'h1
`define SPM_IDX_MODE     6'h20
`define SPM_IDX_STATUS   6'h21

// Count sync control fields
`define SPM_CS_DIAG      1:0
`define SPM_CS_SYNC      4:2
`define SPM_CS_TEST      5
`define SPM_CS_LEVEL     6
`define SPM_CS_REQ       7

// Page register and page number fields
`define SPM_PG_A3        0
`define SPM_PG_NUM       7:1
`define SPM_PG_TOP       6:5
`define SPM_PG_CH        4:3
`define SPM_PG_KIND      2:1
`define SPM_PG_HALF      0
`define SPM_KIND_FIRST   2'h0
`define SPM_MODE_NARROW  0

// Sizes
`define SPM_CHANNELS     4
`define SPM_TAPS         11
`define SPM_FIRST_TAPS   8
`define SPM_NUM_COEF     44
`define SPM_COEF_W       16
`define SPM_CNT_W        24
`define SPM_FRAC_MAX     8'hff
`define SPM_INSEL_W      3

// Codes and constants
`define SPM_INSEL_DIAG0  3'h6
`define SPM_INSEL_DIAG1  3'h7
`define SPM_DIAG_CONST   16'h4000

// Reset values
`define SPM_CSYNC_RST    8'h00
`define SPM_PAGE_RST     8'h00
`define SPM_PERIOD_RST   16'h0000

`endif

// ==== include/spm_pkg.sv ====
package spm_pkg;
`include "spm_defs.svh"

  typedef enum logic [1:0] {
    SPM_DIAG_RAMP  = 2'b00,
    SPM_DIAG_ZERO  = 2'b01,
    SPM_DIAG_SPARE = 2'b10,
    SPM_DIAG_FIXED = 2'b11
  } spm_diag_e;

  typedef logic [`SPM_CHANNELS-1:0][`SPM_COEF_W-1:0]  spm_chan_bus_t;
  typedef logic [`SPM_CHANNELS-1:0][`SPM_INSEL_W-1:0] spm_insel_bus_t;

  typedef struct packed {
    logic       hit;
    logic       hi;
    logic [5:0] tap;
  } spm_coef_sel_s;

  typedef struct packed {
    logic [7:0]                                   csync;
    logic [15:0]                                  period;
    logic [7:0]                                   page;
    logic                                         narrow;
    logic [`SPM_CNT_W-1:0]                        count;
    logic                                         term;
    logic [7:0]                                   hold;
    logic [`SPM_NUM_COEF-1:0][`SPM_COEF_W-1:0]    coef;
    logic                                         pready;
    logic                                         pslverr;
    logic [31:0]                                  prdata;
    spm_chan_bus_t                                chan_out;
  } spm_state_s;

  typedef struct packed {
    logic req_d;
    logic out;
  } spm_shot_s;

endpackage

// ==== core/spm_sync_shot.sv ====
`timescale 1ns/100ps
module spm_sync_shot (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic request,
  input  wire logic level_mode,
  output logic      single_sync_event
);
  import spm_pkg::*;

  spm_shot_s s_r;
  spm_shot_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.req_d = request;
    if (level_mode) begin
      s_nxt.out = request; // RULE5
    end else begin
      // Edge of the request: a held bit never fires twice
      s_nxt.out = request & ~s_r.req_d; // RULE6 RULE7
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign single_sync_event = s_r.out;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  level_follow_a: assert property (request && level_mode |=> single_sync_event) // RULE5
    else $error("level mode sync not active while requested");
  pulse_width_a: assert property ($rose(request) && !level_mode ##1 !level_mode
                                  |-> single_sync_event ##1 !single_sync_event) // RULE6
    else $error("one-shot pulse is not exactly one cycle");
  no_repulse_a: assert property (!level_mode && request && $past(request)
                                 |=> !single_sync_event) // RULE7
    else $error("second pulse without clearing request");
  pulse_seen_c: cover property ($rose(request) && !level_mode ##1 single_sync_event);
endmodule // spm_sync_shot

// ==== core/spm_top.sv ====
`timescale 1ns/100ps
// Operation
// RULE1 - Two-bit test source: ramp, zero, unused, constant
// RULE2 - Test source replaces input only for selection 6/7
// RULE3 - Bits 2-4 pick counter realign sync
// RULE4 - Software keeps factory test bit zero
// RULE5 - Level mode: sync active while request set
// RULE6 - Pulse mode: one clock wide sync pulse
// RULE7 - New pulse only after request cleared, reset
// RULE8 - Sixteen-bit period at addresses 6 and 7
// RULE9 - Counter cycle is 256 times period plus one
// RULE10 - Terminal count flagged at each cycle end; not flagged when a realign lands on the last count
// RULE11 - Software picks cycle multiple of 16N
// RULE12 - Addresses 16-31 decoded through page number
// RULE13 - First filter uses two pages per channel
// RULE14 - Eleven taps: eight then three, rest unused
// RULE15 - Coefficient low byte even, high byte odd
// RULE16 - Software writes low byte before high byte
// RULE17 - Coefficients readable and writable by host
// RULE18 - Addresses 0-7 global, page in bits 1-7
// RULE19 - Narrow mode: page bit 0 is address bit 3
// RULE20 - Low byte held, coefficient updated on high
module spm_top (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [7:0]              sync_sources,
  input  wire spm_pkg::spm_insel_bus_t chan_input_sel,
  input  wire spm_pkg::spm_chan_bus_t  chan_data_in,
  output spm_pkg::spm_chan_bus_t       chan_data_out,
  output logic                         terminal_count_pulse,
  output logic                         single_sync_event
);
  import spm_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Paged window decode, shared by reads and writes
  function automatic spm_coef_sel_s coef_decode(
    input logic [5:0] idx,
    input logic [7:0] page,
    input logic       narrow
  );
    spm_coef_sel_s r;
    logic [3:0]    off;
    logic [6:0]    pg;
    logic [3:0]    local_tap;
    r   = '0;
    // Narrow hosts lack address bit 3, so the page register lends it
    off = narrow ? {page[`SPM_PG_A3], idx[2:0]} : idx[3:0]; // RULE19
    pg  = page[`SPM_PG_NUM]; // RULE18
    if (pg[`SPM_PG_HALF]) begin
      local_tap = 4'(`SPM_FIRST_TAPS) + {1'b0, off[3:1]}; // RULE14
    end else begin
      local_tap = {1'b0, off[3:1]};
    end
    r.hi  = off[0]; // RULE15
    r.tap = 6'(pg[`SPM_PG_CH] * `SPM_TAPS + local_tap); // RULE13
    r.hit = (idx[5:4] == `SPM_IDX_PAGED) && (pg[`SPM_PG_TOP] == 2'h0)
            && (pg[`SPM_PG_KIND] == `SPM_KIND_FIRST)
            && (local_tap < 4'(`SPM_TAPS)); // RULE12 RULE14
    return r;
  endfunction

  function automatic logic is_test_sel(input logic [`SPM_INSEL_W-1:0] sel);
    return (sel == `SPM_INSEL_DIAG0) || (sel == `SPM_INSEL_DIAG1);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  spm_state_s            s_r;
  spm_state_s            s_nxt;
  logic [5:0]            idx;
  logic                  aligned;
  logic                  mapped;
  logic                  setup;
  logic                  access;
  logic                  wr_ok;
  spm_coef_sel_s         cd;
  logic                  realign;
  logic [`SPM_CNT_W-1:0] term_val;
  logic [15:0]           diag_val;

  assign idx      = paddr[7:2];
  assign aligned  = (paddr[1:0] == 2'b00);
  assign mapped   = aligned && ((idx <= `SPM_IDX_GLOB_TOP) || (idx[5:4] == `SPM_IDX_PAGED)
                    || (idx == `SPM_IDX_MODE) || (idx == `SPM_IDX_STATUS)); // RULE18
  assign setup    = psel && !penable;
  assign access   = psel && penable && s_r.pready;
  assign wr_ok    = access && pwrite && !s_r.pslverr && pstrb[0];
  assign cd       = coef_decode(idx, s_r.page, s_r.narrow);
  assign realign  = sync_sources[s_r.csync[`SPM_CS_SYNC]]; // RULE3
  assign term_val = {s_r.period, `SPM_FRAC_MAX}; // RULE9

  // Test source; code 2 has no use and feeds zero
  always_comb begin
    case (spm_diag_e'(s_r.csync[`SPM_CS_DIAG]))
      SPM_DIAG_RAMP:  diag_val = s_r.count[15:0]; // RULE1
      SPM_DIAG_ZERO:  diag_val = 16'h0000; // RULE1
      SPM_DIAG_FIXED: diag_val = `SPM_DIAG_CONST; // RULE1
      default:        diag_val = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;

    // Zero wait states: ready rises in the first access cycle
    s_nxt.pready = setup;
    if (setup) begin
      s_nxt.pslverr = !mapped;
      s_nxt.prdata  = 32'h0000_0000;
      if (mapped) begin
        case (idx)
          `SPM_IDX_PAGE:   s_nxt.prdata[7:0]  = s_r.page; // RULE18
          `SPM_IDX_CSYNC:  s_nxt.prdata[7:0]  = s_r.csync;
          `SPM_IDX_PER_LO: s_nxt.prdata[7:0]  = s_r.period[7:0]; // RULE8
          `SPM_IDX_PER_HI: s_nxt.prdata[7:0]  = s_r.period[15:8]; // RULE8
          `SPM_IDX_MODE:   s_nxt.prdata[0]    = s_r.narrow;
          `SPM_IDX_STATUS: s_nxt.prdata[15:0] = s_r.count[15:0];
          default: begin
            if (cd.hit) begin
              s_nxt.prdata[7:0] = cd.hi ? s_r.coef[cd.tap][15:8]
                                        : s_r.coef[cd.tap][7:0]; // RULE17
            end
          end
        endcase
      end
    end

    if (wr_ok) begin
      case (idx)
        `SPM_IDX_PAGE:   s_nxt.page         = pwdata[7:0]; // RULE18
        `SPM_IDX_CSYNC:  s_nxt.csync        = pwdata[7:0];
        `SPM_IDX_PER_LO: s_nxt.period[7:0]  = pwdata[7:0]; // RULE8
        `SPM_IDX_PER_HI: s_nxt.period[15:8] = pwdata[7:0]; // RULE8
        `SPM_IDX_MODE:   s_nxt.narrow       = pwdata[`SPM_MODE_NARROW]; // RULE19
        default: begin
          if (cd.hit && !cd.hi) begin
            s_nxt.hold = pwdata[7:0]; // RULE20
          end else if (cd.hit) begin
            // A high byte with no fresh low byte reuses a stale one
            s_nxt.coef[cd.tap] = {pwdata[7:0], s_r.hold}; // RULE15 RULE20
          end
        end
      endcase
    end

    // Realign has priority over the wrap
    if (realign) begin
      s_nxt.count = '0; // RULE3
      s_nxt.term  = 1'b0;
    end else if (s_r.count == term_val) begin
      s_nxt.count = '0; // RULE9
      s_nxt.term  = 1'b1; // RULE10
    end else begin
      s_nxt.count = s_r.count + `SPM_CNT_W'(1); // RULE9
      s_nxt.term  = 1'b0;
    end

    for (int ch = 0; ch < `SPM_CHANNELS; ch++) begin
      if (is_test_sel(chan_input_sel[ch])) begin
        s_nxt.chan_out[ch] = diag_val; // RULE2
      end else begin
        s_nxt.chan_out[ch] = chan_data_in[ch]; // RULE2
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_r        <= '0;
      s_r.csync  <= `SPM_CSYNC_RST;
      s_r.page   <= `SPM_PAGE_RST;
      s_r.period <= `SPM_PERIOD_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Factory test bit is stored only; no test behaviour is built
  spm_sync_shot u_shot (
    .clk               (clk),
    .nrst              (nrst),
    .request           (s_r.csync[`SPM_CS_REQ]),
    .level_mode        (s_r.csync[`SPM_CS_LEVEL]),
    .single_sync_event (single_sync_event)
  );

  assign prdata               = s_r.prdata;
  assign pready               = s_r.pready;
  assign pslverr              = s_r.pslverr;
  assign chan_data_out        = s_r.chan_out;
  assign terminal_count_pulse = s_r.term;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Tap of the previous cycle, for checks that look one write back
  logic [5:0]  tap_q;
  logic [15:0] coef_hi_val;

  always_ff @(posedge clk) begin
    tap_q <= cd.tap;
  end

  assign coef_hi_val = s_r.coef[tap_q];

  bus_ready_a: assert property (setup |=> pready ##1 !pready || (psel && !penable))
    else $error("ready not one cycle after setup");
  diag_ramp_a: assert property (is_test_sel(chan_input_sel[0])
                && s_r.csync[`SPM_CS_DIAG] == 2'b00
                |=> chan_data_out[0] == $past(s_r.count[15:0])) // RULE1
    else $error("ramp test source wrong");
  diag_fixed_a: assert property (is_test_sel(chan_input_sel[1])
                 && s_r.csync[`SPM_CS_DIAG] == 2'b11
                 |=> chan_data_out[1] == `SPM_DIAG_CONST) // RULE1
    else $error("constant test source wrong");
  pass_thru_a: assert property (!is_test_sel(chan_input_sel[2])
                |=> chan_data_out[2] == $past(chan_data_in[2])) // RULE2
    else $error("channel input not passed through");
  realign_a: assert property (realign |=> s_r.count == '0 && !terminal_count_pulse) // RULE3
    else $error("counter not realigned by selected sync");
  period_rd_a: assert property (setup && !pwrite && paddr == 8'h1c
                |=> prdata[7:0] == s_r.period[15:8] && prdata[31:8] == '0) // RULE8
    else $error("period high byte readback wrong");
  count_step_a: assert property (!realign && s_r.count != term_val
                 |=> s_r.count == $past(s_r.count) + 1) // RULE9
    else $error("counter did not advance");
  wrap_term_a: assert property (!realign && s_r.count == term_val
                |=> s_r.count == '0 && terminal_count_pulse ##1 !terminal_count_pulse) // RULE9 RULE10
    else $error("terminal count or wrap wrong");
  coef_store_a: assert property (wr_ok && cd.hit && cd.hi
                 |=> coef_hi_val == {$past(pwdata[7:0]), $past(s_r.hold)}) // RULE20
    else $error("coefficient not assembled from held low byte");
  unused_page_a: assert property (setup && idx[5:4] == 2'h1 && !cd.hit
                  |=> prdata == '0) // RULE14
    else $error("unused paged address did not read zero");

  ////////////////////////////////////////////////////////////////////////
  // Register window readback and error answers
  page_rd_a: assert property (setup && !pwrite && mapped && idx == `SPM_IDX_PAGE
               |=> prdata == {24'h0, $past(s_r.page)}) // RULE18
    else $error("page register readback wrong");
  csync_rd_a: assert property (setup && !pwrite && mapped && idx == `SPM_IDX_CSYNC
                |=> prdata == {24'h0, $past(s_r.csync)}) // RULE3
    else $error("count sync control readback wrong");
  per_lo_rd_a: assert property (setup && !pwrite && mapped && idx == `SPM_IDX_PER_LO
                 |=> prdata == {24'h0, $past(s_r.period[7:0])}) // RULE8
    else $error("period low byte readback wrong");
  glob_zero_a: assert property (setup && mapped && idx < `SPM_IDX_PAGE
                 |=> prdata == '0) // RULE18
    else $error("empty global address did not read zero");
  err_rd_a: assert property (setup && !mapped |=> pslverr && prdata == '0) // RULE18
    else $error("unmapped access not flagged");
  ok_rd_a: assert property (setup && mapped |=> !pslverr) // RULE18
    else $error("mapped access flagged as error");
  ready_idle_a: assert property (!psel |=> !pready)
    else $error("ready without a request");

  // Writes land only where they should
  err_nowr_a: assert property (access && pwrite && s_r.pslverr
                |=> $stable(s_r.page) && $stable(s_r.csync)
                    && $stable(s_r.period) && $stable(s_r.hold)) // RULE18
    else $error("refused write changed a register");
  strobe_a: assert property (access && pwrite && !pstrb[0]
              |=> $stable(s_r.page) && $stable(s_r.csync)
                  && $stable(s_r.period) && $stable(s_r.hold)) // RULE8
    else $error("write without strobe changed a register");
  per_lo_wr_a: assert property (wr_ok && idx == `SPM_IDX_PER_LO
                 |=> s_r.period[7:0] == $past(pwdata[7:0])) // RULE8
    else $error("period low byte not written");
  per_hi_wr_a: assert property (wr_ok && idx == `SPM_IDX_PER_HI
                 |=> s_r.period[15:8] == $past(pwdata[7:0])) // RULE8
    else $error("period high byte not written");
  page_wr_a: assert property (wr_ok && idx == `SPM_IDX_PAGE
               |=> s_r.page == $past(pwdata[7:0])) // RULE18
    else $error("page register not written");

  // Coefficient pairing and readback
  hold_wr_a: assert property (wr_ok && cd.hit && !cd.hi
               |=> s_r.hold == $past(pwdata[7:0])) // RULE20
    else $error("low byte not captured in holding register");
  low_keep_a: assert property (wr_ok && cd.hit && !cd.hi
                |=> coef_hi_val == $past(s_r.coef[cd.tap])) // RULE20
    else $error("low byte alone changed a coefficient");
  coef_lo_rd_a: assert property (setup && aligned && cd.hit && !cd.hi
                  |=> prdata == {24'h0, $past(s_r.coef[cd.tap][7:0])}) // RULE17
    else $error("coefficient low byte readback wrong");
  coef_hi_rd_a: assert property (setup && aligned && cd.hit && cd.hi
                  |=> prdata == {24'h0, $past(s_r.coef[cd.tap][15:8])}) // RULE15
    else $error("coefficient high byte readback wrong");
  narrow_tap_a: assert property (s_r.narrow && cd.hit && s_r.page[`SPM_PG_NUM] == '0
                  |-> cd.tap == {3'h0, s_r.page[`SPM_PG_A3], idx[2:1]}) // RULE19
    else $error("narrow mode tap decode wrong");
  wide_tap_a: assert property (!s_r.narrow && cd.hit && s_r.page[`SPM_PG_NUM] == '0
                |-> cd.tap == {3'h0, idx[3:1]}) // RULE14
    else $error("first page tap decode wrong");

  // Counter, test source and one-shot seen from the top
  term_zero_a: assert property (terminal_count_pulse |-> s_r.count == '0) // RULE10
    else $error("terminal pulse away from counter wrap");
  term_once_a: assert property (terminal_count_pulse |=> !terminal_count_pulse) // RULE10
    else $error("terminal pulse longer than one cycle");
  diag_zero_a: assert property (is_test_sel(chan_input_sel[0])
                 && spm_diag_e'(s_r.csync[`SPM_CS_DIAG]) == SPM_DIAG_ZERO
                 |=> chan_data_out[0] == '0) // RULE1
    else $error("zero test source wrong");
  diag_spare_a: assert property (is_test_sel(chan_input_sel[0])
                  && spm_diag_e'(s_r.csync[`SPM_CS_DIAG]) == SPM_DIAG_SPARE
                  |=> chan_data_out[0] == '0) // RULE1
    else $error("unused test source code not zero");
  level_top_a: assert property (s_r.csync[`SPM_CS_REQ] && s_r.csync[`SPM_CS_LEVEL]
                 |=> single_sync_event) // RULE5
    else $error("level sync missing while requested");
  shot_quiet_a: assert property (!s_r.csync[`SPM_CS_REQ] |=> !single_sync_event) // RULE6
    else $error("sync event without request");

  // Every channel obeys its own selection
  for (genvar ch = 0; ch < `SPM_CHANNELS; ch++) begin : g_chan_chk
    chan_sel_a: assert property (is_test_sel(chan_input_sel[ch])
                  |=> chan_data_out[ch] == $past(diag_val)) // RULE2
      else $error("test source not routed to channel");
    chan_pass_a: assert property (!is_test_sel(chan_input_sel[ch])
                   |=> chan_data_out[ch] == $past(chan_data_in[ch])) // RULE2
      else $error("channel input not passed through");
  end

  term_seen_c:  cover property (terminal_count_pulse);
  realign_c:    cover property (realign && s_r.count != '0);
  coef_wr_c:    cover property (wr_ok && cd.hit && cd.hi && s_r.narrow);
  diag_const_c: cover property (is_test_sel(chan_input_sel[3])
                                && s_r.csync[`SPM_CS_DIAG] == 2'b11);
endmodule // spm_top

// ==== dv/tb.sv ====
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module tb;
  import spm_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [31:0] e; logic err;} spm_row_s;
  logic           clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]     paddr = 8'h00, sync_src = 8'h00;
  logic [31:0]    pwdata = 32'h0, prdata, rv;
  logic [3:0]     pstrb = 4'hf;
  logic           pready, pslverr, tcp, sse, ev;
  spm_insel_bus_t insel = {3'h5, 3'h0, 3'h7, 3'h6};
  spm_chan_bus_t  din = {16'h4444, 16'h3333, 16'h2222, 16'h1111}, dout;
  logic [15:0]    a, b, x;
  int             n_fail = 0, tests_run = 0, c, g;
  spm_row_s       rows [10] = '{
    '{8'h08, 8'hfe, 32'hfe, 1'b0}, '{8'h18, 8'h5a, 32'h5a, 1'b0},
    '{8'h1c, 8'ha5, 32'ha5, 1'b0}, '{8'h14, 8'h1e, 32'h1e, 1'b0},
    '{8'h00, 8'h55, 32'h00, 1'b0}, '{8'h20, 8'h66, 32'h00, 1'b1},
    '{8'hc0, 8'h77, 32'h00, 1'b1}, '{8'h19, 8'h88, 32'h00, 1'b1},
    '{8'h1c, 8'h00, 32'h00, 1'b0}, '{8'h18, 8'h00, 32'h00, 1'b0}};

  spm_top DUT (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sync_sources(sync_src), .chan_input_sel(insel),
    .chan_data_in(din), .chan_data_out(dout), .terminal_count_pulse(tcp),
    .single_sync_event(sse)
  );

  always #20 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Request held from setup until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] ad, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    `CHK(pready, 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    apb(1'b1, {i, 2'b00}, d);
  endtask

  task automatic chk_rd(input logic [5:0] i, input logic [7:0] e);
    apb(1'b0, {i, 2'b00}, 8'h00);
    `CHK(rv, {24'h0, e});
    `CHK(ev, 1'b0);
  endtask

  // Cycles between two terminal pulses; the first pulse only starts the count
  task automatic tc_gap(output int n);
    int k;
    k = 0;
    while (tcp !== 1'b1 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    @(posedge clk);
    n = 1;
    while (tcp !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic cnt_hi(input int n, input logic sel, output int m);
    m = 0;
    repeat (n) begin
      @(posedge clk);
      if ((sel ? tcp : sse) === 1'b1) m++;
    end
  endtask

  function automatic logic [7:0] cv(input int ch, input int k);
    return {ch[1:0], k[5:0]};
  endfunction

  task results;
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    results;
  end

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 5; i < 8; i++) chk_rd(6'(i), 8'h00);
    chk_rd(6'h02, 8'h00);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      `CHK(ev, rows[i].err);
      apb(1'b0, rows[i].a, 8'h00);
      `CHK({rv, ev}, {rows[i].e, rows[i].err});
    end
    // Strobe off: write must leave the period untouched
    pstrb <= 4'h0;
    wr(6'h06, 8'h33);
    pstrb <= 4'hf;
    chk_rd(6'h06, 8'h00);
    // Held sync keeps the counter at zero with no terminal pulse; released, period 0 then 2 gives gaps of 256 and 768
    wr(6'h05, 8'h0c);
    sync_src <= 8'h08;
    cnt_hi(1000, 1'b1, c);
    `CHK(c, 0);
    sync_src <= 8'hf7;
    tc_gap(g);
    `CHK(g, 256);
    wr(6'h06, 8'h02);
    tc_gap(g);
    `CHK(g, 768);
    sync_src <= 8'h00;
    for (int s = 1; s < 4; s++) begin
      wr(6'h05, 8'(s));
      repeat (3) @(posedge clk);
      x = (s == 3) ? 16'h4000 : 16'h0000;
      `CHK({dout[1], dout[0]}, {x, x});
      `CHK(dout[3:2], {16'h4444, 16'h3333});
    end
    // Long period so the low ramp bits never wrap early
    wr(6'h06, 8'hff);
    wr(6'h07, 8'hff);
    wr(6'h05, 8'h00);
    repeat (3) @(posedge clk);
    a = dout[0];
    @(posedge clk);
    b = dout[0];
    `CHK(16'(b - a), 16'h0001);
    `CHK(dout[1], b);
    wr(6'h05, 8'h80);
    cnt_hi(20, 1'b0, c);
    `CHK(c, 1);
    wr(6'h05, 8'h80);
    cnt_hi(20, 1'b0, c);
    `CHK(c, 0);
    wr(6'h05, 8'h00);
    wr(6'h05, 8'h80);
    cnt_hi(20, 1'b0, c);
    `CHK(c, 1);
    wr(6'h05, 8'hc0);
    cnt_hi(3, 1'b0, c);
    cnt_hi(10, 1'b0, c);
    `CHK(c, 10);
    wr(6'h05, 8'h40);
    cnt_hi(3, 1'b0, c);
    cnt_hi(10, 1'b0, c);
    `CHK(c, 0);
    for (int ch = 0; ch < 4; ch++) begin
      wr(6'h02, 8'(ch << 4));
      wr(6'h10, cv(ch, 0));
      wr(6'h11, cv(ch, 1));
      wr(6'h1e, cv(ch, 2));
      wr(6'h1f, cv(ch, 3));
      wr(6'h02, 8'((ch << 4) | 2));
      wr(6'h14, cv(ch, 4));
      wr(6'h15, cv(ch, 5));
      wr(6'h16, 8'h77);
    end
    for (int ch = 0; ch < 4; ch++) begin
      wr(6'h02, 8'(ch << 4));
      chk_rd(6'h10, cv(ch, 0));
      chk_rd(6'h11, cv(ch, 1));
      chk_rd(6'h1e, cv(ch, 2));
      chk_rd(6'h1f, cv(ch, 3));
      wr(6'h02, 8'((ch << 4) | 2));
      chk_rd(6'h14, cv(ch, 4));
      chk_rd(6'h15, cv(ch, 5));
      chk_rd(6'h16, 8'h00);
    end
    // Low byte alone stays in the holding register
    wr(6'h02, 8'h00);
    wr(6'h10, 8'hee);
    chk_rd(6'h10, cv(0, 0));
    wr(6'h11, 8'hdd);
    chk_rd(6'h10, 8'hee);
    chk_rd(6'h11, 8'hdd);
    wr(6'h02, 8'h04);
    wr(6'h10, 8'h99);
    chk_rd(6'h10, 8'h00);
    wr(6'h20, 8'h01);
    wr(6'h02, 8'h01);
    wr(6'h10, 8'h5c);
    wr(6'h11, 8'hc5);
    wr(6'h20, 8'h00);
    wr(6'h02, 8'h00);
    chk_rd(6'h18, 8'h5c);
    chk_rd(6'h19, 8'hc5);
    results;
  end
endmodule // tb
